// ---- hw/power_state_controller.v ----
`timescale 1ns/100ps
`include "psc_defines.vh"
// Functional notes
// RQ1: Track no-supply, backup, off, active and sleep power states.
// RQ2: Only five sequenced transitions exist, each running a fixed sequence.
// RQ3: Reach off about 5.5 ms after supply appears.
// RQ4: Remote on pin, low, debounced 16 ms; partner holds it that long.
// RQ5: On key low is an undebounced level ON request.
// RQ6: Unmasked interrupt edges are ON requests; all masked after reset.
// RQ7: Hold pin high is an ON request, debounced a few milliseconds.
// RQ8: Low supply sense, hot die, force-down or reset-in block ON requests.
// RQ9: OFF requests win over everything and are never gated.
// RQ10: After an OFF, ignore ON until that OFF request drops.
// RQ11: Common 0/1/2/4 s delay for listed sources; others act at once.
// RQ12: Each OFF applies hardware or switch-off reset level per source.
// RQ13: Each OFF shuts down or cold restarts unless gating holds.
// RQ14: Watchdog source disabled at reset; software enables, then locks it.
// RQ15: Keep-on bit and hold pin force off only when both are inactive.
// RQ16: Active sleep pin starts active-to-sleep unless unmasked interrupt pending.
// RQ17: Interrupt or inactive sleep pin wakes, only in sleep state.
// RQ18: Direct-pin resources switch at once; sleep-pin ones follow sequence.
// RQ19: Resources on both pins: either pin inactive keeps them active; code keeps them active only outside sleep state or on active direct pin.
// RQ20: Resources on neither pin always stay active.
// RQ21: Sleep and direct pin polarities are software selectable.
// RQ22: All direct-pin resources switch in the same cycle.
// RQ23: Auto keep-on mode sets keep-on bit when power-up completes.
// RQ24: Inputs synchronised; priority OFF, then sleep or wake, then ON.
// RQ25: No new request is taken while a sequence runs.
module power_state_controller #(
  parameter        N_IRQ          = 8,
  parameter        N_RES          = 8,
  parameter        REMOTE_DEB_CYC = `REMOTE_DEB_US * (`CLK_KHZ / 1000),
  parameter        HOLD_DEB_CYC   = `HOLD_DEB_US * (`CLK_KHZ / 1000),
  parameter        BOOT_CYC       = `BOOT_US * (`CLK_KHZ / 1000),
  parameter [31:0] SWOFF_STEP_CYC = `SWOFF_STEP_MS * `CLK_KHZ,
  parameter [31:0] POLICY_RST     = `POLICY_RST
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // AXI4-Lite register port
  input  wire [7:0]       awaddr,
  input  wire             awvalid,
  output wire             awready,
  input  wire [31:0]      wdata,
  input  wire [3:0]       wstrb,
  input  wire             wvalid,
  output wire             wready,
  output wire [1:0]       bresp,
  output wire             bvalid,
  input  wire             bready,
  input  wire [7:0]       araddr,
  input  wire             arvalid,
  output wire             arready,
  output wire [31:0]      rdata,
  output wire [1:0]       rresp,
  output wire             rvalid,
  input  wire             rready,
  // Request pins
  input  wire             remote_on_pin_n,
  input  wire             on_key_pin_n,
  input  wire             long_press_event,
  input  wire             hold_on_pin,
  input  wire             force_down_pin,
  input  wire             reset_in_pin,
  input  wire             sleep_request_pin,
  input  wire             direct_mode_pin,
  // Supply, thermal and internal events
  input  wire             por_ok,
  input  wire             low_supply_event,
  input  wire             high_supply_ok,
  input  wire             die_overtemp_event,
  input  wire             thermal_shutdown_event,
  input  wire             watchdog_timeout,
  input  wire             converter_shutdown_event,
  input  wire [N_IRQ-1:0] irq_events,
  // Sequencer handshake
  output wire             seq_start,
  output wire [2:0]       seq_sel,
  input  wire             seq_done,
  // State and resource outputs
  output wire [2:0]       power_state,
  output wire [N_RES-1:0] res_sleep,
  output wire             hw_reset_pulse,
  output wire             swoff_reset_pulse
);

  localparam [2:0] ST_NOSUP  = 3'h0;
  localparam [2:0] ST_BACKUP = 3'h1;
  localparam [2:0] ST_OFF    = 3'h2;
  localparam [2:0] ST_ACTIVE = 3'h3;
  localparam [2:0] ST_SLEEP  = 3'h4;
  localparam       NS        = 15 + N_IRQ;

  function [31:0] bmask;
    input [3:0] s;
    bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function [31:0] merge;
    input [31:0] o;
    input [31:0] d;
    input [3:0]  s;
    merge = (o & ~bmask(s)) | (d & bmask(s));
  endfunction

  function addr_ok;
    input [7:0] a;
    addr_ok = (a[1:0] == 2'h0) && (a <= `OFS_STATUS);
  endfunction

  function [3:0] first_src;
    input [`N_OFF-1:0] v;
    integer i;
    begin
      first_src = 4'h0;
      for (i = `N_OFF - 1; i >= 0; i = i - 1)
        if (v[i])
          first_src = i[3:0];
    end
  endfunction

  reg  [NS-1:0]     sync1_r, sync2_r;
  reg  [N_IRQ-1:0]  irq_prev_r, irq_mask_r;
  reg  [N_RES-1:0]  sleep_asg_r, en_asg_r, res_sleep_r;
  reg  [6:0]        cfg_r;
  reg  [8:0]        lvl_r, cr_r;
  reg               keep_on_r, swrst_r, auto_keep_r, wdt_en_r, wdt_lock_r;
  reg               awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  reg  [1:0]        bresp_r, rresp_r;
  reg  [31:0]       rdata_r, rd_val, dly_cnt_r, dly_tgt, boot_cnt_r;
  reg  [2:0]        pstate_r, target_r, seq_sel_r;
  reg  [3:0]        off_idx_r;
  reg               busy_r, seq_start_r, off_block_r, restart_r, lvl_hw_r;
  reg               hardware_reset_level_r, swoff_r, acked_r, keep_set_r, keep_clr_r;
  wire [N_RES-1:0]  res_nxt;
  wire [`N_OFF-1:0] src, fire;
  wire              remote_deb, hold_deb;

  // Every request input passes two flops before any decision
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r    <= {NS{1'b0}};
      sync2_r    <= {NS{1'b0}};
      irq_prev_r <= {N_IRQ{1'b0}};
    end
    else
    begin
      sync1_r    <= {irq_events, converter_shutdown_event, watchdog_timeout,
                     thermal_shutdown_event, die_overtemp_event, high_supply_ok,
                     low_supply_event, por_ok, direct_mode_pin, sleep_request_pin,
                     reset_in_pin, force_down_pin, hold_on_pin, long_press_event,
                     on_key_pin_n, remote_on_pin_n}; // RQ24
      sync2_r    <= sync1_r;
      irq_prev_r <= sync2_r[NS-1:15];
    end
  end

  wire              s_onkey_n = sync2_r[1];
  wire              s_lowsup  = sync2_r[9];
  wire              s_por     = sync2_r[8];
  wire [N_IRQ-1:0]  s_irq     = sync2_r[NS-1:15];

  // Slow filters; an idle remote pin reads as no request
  debounce_filter #(.CYC(REMOTE_DEB_CYC)) u_remote_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (~sync2_r[0]),
    .dout    (remote_deb)
  ); // RQ4
  debounce_filter #(.CYC(HOLD_DEB_CYC)) u_hold_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (sync2_r[3]),
    .dout    (hold_deb)
  ); // RQ7

  // Pin meanings after polarity selection
  wire fdown_act  = sync2_r[4] ^ cfg_r[`CFG_FDOWN_POL];
  wire rstin_act  = sync2_r[5] ^ cfg_r[`CFG_RSTIN_POL];
  wire sleep_act  = ~sync2_r[6] ^ cfg_r[`CFG_SLEEP_POL]; // RQ21
  wire en_act     = sync2_r[7] ^ cfg_r[`CFG_EN_POL]; // RQ21
  wire irq_pend   = |(s_irq & ~irq_mask_r);
  wire irq_edge   = |(s_irq & ~irq_prev_r & ~irq_mask_r); // RQ6
  wire gate       = ~sync2_r[10] | sync2_r[11] | fdown_act | rstin_act; // RQ8
  wire on_req     = remote_deb | ~s_onkey_n | hold_deb | irq_edge; // RQ5
  wire sleep_req  = sleep_act & ~cfg_r[`CFG_SLEEP_MASK]; // RQ16
  wire wake       = irq_pend | ~sleep_req; // RQ17
  wire run_state  = (pstate_r == ST_ACTIVE) || (pstate_r == ST_SLEEP);

  // OFF sources, bit order fixes which one is recorded when several coincide
  assign src = {s_lowsup,
                acked_r & ~keep_on_r & ~hold_deb, // RQ15
                swrst_r, sync2_r[12], sync2_r[14], rstin_act,
                sync2_r[13] & wdt_en_r, // RQ14
                fdown_act, sync2_r[2]};

  // Common switch-off delay; delay 0 lets delayed sources act at once
  always @*
  begin
    case (cfg_r[`CFG_DLY_MSB:`CFG_DLY_LSB])
      2'h0:    dly_tgt = 32'h0;
      2'h1:    dly_tgt = SWOFF_STEP_CYC;
      2'h2:    dly_tgt = SWOFF_STEP_CYC << 1;
      default: dly_tgt = SWOFF_STEP_CYC << 2;
    endcase
  end

  // Delay restarts whenever every delayed source has gone away
  always @(posedge aclk)
  begin
    if (!aresetn)
      dly_cnt_r <= 32'h0;
    else if (run_state && |(src & `OFF_DELAYED) && dly_cnt_r < dly_tgt)
      dly_cnt_r <= dly_cnt_r + 32'h1;
    else if (!(run_state && |(src & `OFF_DELAYED)))
      dly_cnt_r <= 32'h0;
  end

  assign fire = src & (~`OFF_DELAYED | {`N_OFF{dly_cnt_r >= dly_tgt}}); // RQ11

  task start_seq;
    input [2:0] sel;
    input [2:0] tgt;
    begin
      seq_sel_r   <= sel;
      target_r    <= tgt;
      seq_start_r <= 1'b1;
      busy_r      <= 1'b1;
    end
  endtask

  // Power state machine; a running sequence holds off every request
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pstate_r    <= ST_NOSUP;
      target_r    <= ST_NOSUP;
      seq_sel_r   <= `SEQ_NONE;
      off_idx_r   <= 4'h0;
      boot_cnt_r  <= 32'h0;
      busy_r      <= 1'b0;
      seq_start_r <= 1'b0;
      off_block_r <= 1'b0;
      restart_r   <= 1'b0;
      lvl_hw_r    <= 1'b0;
      hardware_reset_level_r     <= 1'b0;
      swoff_r     <= 1'b0;
      acked_r     <= 1'b0;
      keep_set_r  <= 1'b0;
      keep_clr_r  <= 1'b0;
    end
    else
    begin
      seq_start_r <= 1'b0;
      hardware_reset_level_r     <= 1'b0;
      swoff_r     <= 1'b0;
      keep_set_r  <= 1'b0;
      keep_clr_r  <= 1'b0;
      if (!s_por)
      begin
        pstate_r    <= ST_NOSUP; // RQ1
        busy_r      <= 1'b0;
        acked_r     <= 1'b0;
        off_block_r <= 1'b0;
      end
      else if (busy_r)
      begin
        if (seq_done) // RQ25
        begin
          busy_r   <= 1'b0;
          pstate_r <= target_r;
          if (seq_sel_r == `SEQ_OFF_TO_ACTIVE_SEQ && auto_keep_r)
            keep_set_r <= 1'b1; // RQ23
          if (target_r == ST_OFF)
          begin
            hardware_reset_level_r    <= lvl_hw_r; // RQ12
            swoff_r    <= ~lvl_hw_r;
            keep_clr_r <= 1'b1;
            acked_r    <= 1'b0;
            if (restart_r && !gate)
              start_seq(`SEQ_OFF_TO_ACTIVE_SEQ, ST_ACTIVE); // RQ13
            else
              off_block_r <= 1'b1; // RQ10
          end
        end
      end
      else
      begin
        case (pstate_r)
          ST_NOSUP:
          begin
            pstate_r   <= ST_BACKUP;
            boot_cnt_r <= 32'h0;
          end
          ST_BACKUP:
          begin
            if (boot_cnt_r < BOOT_CYC - 1)
              boot_cnt_r <= boot_cnt_r + 32'h1;
            else if (!s_lowsup)
              pstate_r <= ST_OFF; // RQ3
          end
          ST_OFF:
          begin
            if (s_lowsup)
              pstate_r <= ST_BACKUP;
            else if (off_block_r)
              off_block_r <= src[off_idx_r]; // RQ10
            else if (on_req && !gate)
              start_seq(`SEQ_OFF_TO_ACTIVE_SEQ, ST_ACTIVE); // RQ2
          end
          ST_ACTIVE, ST_SLEEP:
          begin
            if (|fire) // RQ9
            begin
              off_idx_r <= first_src(fire);
              lvl_hw_r  <= (first_src(fire) == `OFF_LONGKEY) ||
                           ((first_src(fire) != `OFF_ACKLOST) && lvl_r[first_src(fire)]);
              restart_r <= (first_src(fire) != `OFF_LONGKEY) &&
                           (first_src(fire) != `OFF_ACKLOST) && cr_r[first_src(fire)];
              if (pstate_r == ST_ACTIVE)
                start_seq(`SEQ_ACTIVE_TO_OFF_SEQ, ST_OFF); // RQ2
              else
                start_seq(`SEQ_SLEEP_TO_OFF_SEQ, ST_OFF);
            end
            else if (pstate_r == ST_ACTIVE)
            begin
              if (sleep_req && !irq_pend)
                start_seq(`SEQ_ACTIVE_TO_SLEEP_SEQ, ST_SLEEP); // RQ16
              else if (keep_on_r || hold_deb)
                acked_r <= 1'b1;
            end
            else if (wake)
              start_seq(`SEQ_SLEEP_TO_ACTIVE_SEQ, ST_ACTIVE); // RQ17
          end
          default:
            pstate_r <= ST_NOSUP;
        endcase
      end
    end
  end

  // Resource power modes; direct pin acts the same cycle on every resource assigned to it
  genvar g;
  generate
    for (g = 0; g < N_RES; g = g + 1)
    begin : g_res
      assign res_nxt[g] = en_asg_r[g] ? ~en_act & (~sleep_asg_r[g] | // RQ18
                                       (pstate_r == ST_SLEEP)) : // RQ19
                          sleep_asg_r[g] & (pstate_r == ST_SLEEP); // RQ20
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
      res_sleep_r <= {N_RES{1'b0}};
    else
      res_sleep_r <= res_nxt; // RQ22
  end

  // Bus handshakes: ready for one cycle once the read address or both write halves are offered
  wire wr_fire = awvalid & wvalid & ~awready_r & ~bvalid_r;
  wire wr_do   = awvalid & wvalid & awready_r;
  wire rd_fire = arvalid & ~arready_r & ~rvalid_r;
  wire rd_do   = arvalid & arready_r;
  wire [31:0] ctrl_rd = {27'h0, wdt_lock_r, wdt_en_r, auto_keep_r, 1'b0, keep_on_r};

  always @*
  begin
    case (araddr)
      `OFS_CTRL:      rd_val = ctrl_rd;
      `OFS_CFG:       rd_val = {25'h0, cfg_r};
      `OFS_POLICY:    rd_val = {7'h0, cr_r, 7'h0, lvl_r};
      `OFS_IRQ_MASK:  rd_val = {{(32 - N_IRQ){1'b0}}, irq_mask_r};
      `OFS_SLEEP_ASG: rd_val = {{(32 - N_RES){1'b0}}, sleep_asg_r};
      `OFS_EN_ASG:    rd_val = {{(32 - N_RES){1'b0}}, en_asg_r};
      `OFS_STATUS:    rd_val = {22'h0, acked_r, off_block_r, off_idx_r, busy_r, pstate_r};
      default:        rd_val = 32'h0;
    endcase
  end

  // Register file; hardware sets of the keep-on bit win over software writes
  always @(posedge aclk)
  begin : regs
    reg [31:0] nv;
    nv = 32'h0;
    if (!aresetn)
    begin
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `RESP_OKAY;
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rresp_r     <= `RESP_OKAY;
      rdata_r     <= 32'h0;
      keep_on_r   <= 1'b0;
      swrst_r     <= 1'b0;
      auto_keep_r <= 1'b0;
      wdt_en_r    <= 1'b0; // RQ14
      wdt_lock_r  <= 1'b0;
      cfg_r       <= `CFG_RST;
      lvl_r       <= POLICY_RST[8:0];
      cr_r        <= POLICY_RST[`POL_CR_LSB+8:`POL_CR_LSB];
      irq_mask_r  <= {N_IRQ{1'b1}}; // RQ6
      sleep_asg_r <= {N_RES{1'b0}};
      en_asg_r    <= {N_RES{1'b0}};
    end
    else
    begin
      awready_r <= wr_fire;
      wready_r  <= wr_fire;
      arready_r <= rd_fire;
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= addr_ok(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (awaddr)
          `OFS_CTRL:
          begin
            nv          = merge(ctrl_rd, wdata, wstrb);
            keep_on_r   <= nv[`CTRL_KEEP_ON];
            auto_keep_r <= nv[`CTRL_AUTO_KEEP];
            if (!wdt_lock_r) // RQ14
            begin
              wdt_en_r   <= nv[`CTRL_WDT_EN];
              wdt_lock_r <= nv[`CTRL_WDT_LOCK];
            end
          end
          `OFS_CFG:
          begin
            nv    = merge({25'h0, cfg_r}, wdata, wstrb);
            cfg_r <= nv[`CFG_SLEEP_MASK:0];
          end
          `OFS_POLICY:
          begin
            nv    = merge({7'h0, cr_r, 7'h0, lvl_r}, wdata, wstrb);
            lvl_r <= nv[8:0];
            cr_r  <= nv[`POL_CR_LSB+8:`POL_CR_LSB];
          end
          `OFS_IRQ_MASK:  irq_mask_r <= wdata[N_IRQ-1:0];
          `OFS_SLEEP_ASG: sleep_asg_r <= wdata[N_RES-1:0];
          `OFS_EN_ASG:    en_asg_r <= wdata[N_RES-1:0];
          default:        nv = 32'h0;
        endcase
      end
      else if (bready)
        bvalid_r <= 1'b0;
      // Software reset request stays until the device has reached off
      if (pstate_r == ST_OFF)
        swrst_r <= 1'b0;
      if (wr_do && awaddr == `OFS_CTRL && wstrb[0] && wdata[`CTRL_SW_RESET])
        swrst_r <= 1'b1;
      if (keep_clr_r)
        keep_on_r <= 1'b0;
      if (keep_set_r)
        keep_on_r <= 1'b1; // RQ23
      if (rd_do)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rready)
        rvalid_r <= 1'b0;
    end
  end

  assign awready           = awready_r;
  assign wready            = wready_r;
  assign bvalid            = bvalid_r;
  assign bresp             = bresp_r;
  assign arready           = arready_r;
  assign rvalid            = rvalid_r;
  assign rdata             = rdata_r;
  assign rresp             = rresp_r;
  assign seq_start         = seq_start_r;
  assign seq_sel           = seq_sel_r;
  assign power_state       = pstate_r;
  assign res_sleep         = res_sleep_r;
  assign hw_reset_pulse    = hardware_reset_level_r;
  assign swoff_reset_pulse = swoff_r;

endmodule // power_state_controller

// ---- hw/psc_defines.vh ----
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Clock rate and documented times in their own units
`define CLK_KHZ        40000
`define REMOTE_DEB_US  16000
`define HOLD_DEB_US    4000
`define BOOT_US        5500
`define SWOFF_STEP_MS  1000

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_CFG        8'h04
`define OFS_POLICY     8'h08
`define OFS_IRQ_MASK   8'h0C
`define OFS_SLEEP_ASG  8'h10
`define OFS_EN_ASG     8'h14
`define OFS_STATUS     8'h18

// Control register fields
`define CTRL_KEEP_ON   0
`define CTRL_SW_RESET  1
`define CTRL_AUTO_KEEP 2
`define CTRL_WDT_EN    3
`define CTRL_WDT_LOCK  4

// Configuration register fields
`define CFG_DLY_LSB    0
`define CFG_DLY_MSB    1
`define CFG_SLEEP_POL  2
`define CFG_EN_POL     3
`define CFG_FDOWN_POL  4
`define CFG_RSTIN_POL  5
`define CFG_SLEEP_MASK 6
`define CFG_RST        7'h40

// Policy register: reset level low half, cold restart high half
`define POL_CR_LSB     16
`define POLICY_RST     32'h00000000

// Sequence selectors
`define SEQ_NONE       3'h0
`define SEQ_OFF_TO_ACTIVE_SEQ    3'h1
`define SEQ_ACTIVE_TO_OFF_SEQ    3'h2
`define SEQ_ACTIVE_TO_SLEEP_SEQ    3'h3
`define SEQ_SLEEP_TO_ACTIVE_SEQ    3'h4
`define SEQ_SLEEP_TO_OFF_SEQ    3'h5

// OFF request sources
`define N_OFF          9
`define OFF_LONGKEY    4'h0
`define OFF_ACKLOST    4'h7
`define OFF_DELAYED    9'h01F

// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ---- hw/debounce_filter.v ----
`timescale 1ns/100ps
module debounce_filter #(
  parameter CYC = 16
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Raw and filtered level
  input  wire din,
  output wire dout
);

  reg        level_r;
  reg [31:0] cnt_r;

  // A new level must stand unbroken for CYC cycles; a glitch restarts the count
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_r <= 1'b0;
      cnt_r   <= 32'h0;
    end
    else if (din == level_r)
      cnt_r <= 32'h0;
    else if (cnt_r >= CYC - 1)
    begin
      level_r <= din;
      cnt_r   <= 32'h0;
    end
    else
      cnt_r <= cnt_r + 32'h1;
  end

  assign dout = level_r;

endmodule // debounce_filter

// ---- tb/psc_sva.sv ----
`timescale 1ns/100ps
module psc_sva (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshake
  input wire        awvalid,
  input wire        wvalid,
  input wire        awready,
  input wire        bvalid,
  input wire        bready,
  input wire [1:0]  bresp,
  input wire        arvalid,
  input wire        arready,
  input wire        rvalid,
  // Power control
  input wire        die_overtemp_event,
  input wire        seq_start,
  input wire [2:0]  seq_sel,
  input wire        seq_done,
  input wire [2:0]  power_state,
  input wire        hw_reset_pulse
);
  reg busy_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Sequence in flight; supply loss abandons it
  always @(posedge aclk)
    if (!aresetn) busy_r <= 1'b0;
    else if (seq_start) busy_r <= 1'b1;
    else if (seq_done || power_state == 3'h0) busy_r <= 1'b0;
  a_state_legal: assert property (power_state <= 3'h4)
    else $error("power state out of range");
  a_trans_legal: assert property (seq_start |-> (seq_sel == 3'h1 && power_state == 3'h2)
    || ((seq_sel == 3'h2 || seq_sel == 3'h3) && power_state == 3'h3)
    || ((seq_sel == 3'h4 || seq_sel == 3'h5) && power_state == 3'h4))
    else $error("sequence not legal from this state");
  a_one_seq: assert property (seq_start |-> !busy_r)
    else $error("sequence started while busy");
  a_off_done: assert property (busy_r && seq_done && (seq_sel == 3'h2 || seq_sel == 3'h5)
    |=> power_state == 3'h2) else $error("off sequence did not end in off");
  a_sleep_done: assert property (busy_r && seq_done && seq_sel == 3'h3
    |=> power_state == 3'h4) else $error("sleep sequence did not end in sleep");
  a_wake_done: assert property (busy_r && seq_done && (seq_sel == 3'h1 || seq_sel == 3'h4)
    |=> power_state == 3'h3) else $error("on sequence did not end in active");
  a_hw_level: assert property (hw_reset_pulse |-> power_state == 3'h2 ##1 !hw_reset_pulse)
    else $error("reset pulse wrong");
  // A hot die held for several cycles must block the start of power-up
  a_on_gated: assert property (seq_start && seq_sel == 3'h1 |-> !($past(die_overtemp_event, 2)
    && $past(die_overtemp_event, 3) && $past(die_overtemp_event, 4)))
    else $error("power-up while gated");
  a_wr_answer: assert property (awvalid && wvalid && awready |=> bvalid && !awready)
    else $error("write answer late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
endmodule // psc_sva
bind power_state_controller psc_sva i_sva (.aclk, .aresetn, .awvalid, .wvalid, .awready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .die_overtemp_event, .seq_start, .seq_sel,
  .seq_done, .power_state, .hw_reset_pulse, .rvalid);

// ---- tb/seq_model.sv ----
`timescale 1ns/100ps
module seq_model (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Sequencer handshake
  input  wire seq_start,
  input  wire slow,
  output reg  seq_done
);
  reg [3:0] cnt_r;
  reg       run_r;
  // One answer per start; slow mode widens the busy window
  always @(posedge aclk)
  begin
    seq_done <= 1'b0;
    if (!aresetn)
      run_r <= 1'b0;
    else if (seq_start)
    begin
      run_r <= 1'b1;
      cnt_r <= slow ? 4'hA : 4'h0;
    end
    else if (run_r && cnt_r == 4'h0)
    begin
      seq_done <= 1'b1;
      run_r    <= 1'b0;
    end
    else if (run_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule // seq_model

// ---- tb/test_power_state_controller.sv ----
`timescale 1ns/100ps
`include "psc_defines.vh"
module test_power_state_controller;
  reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg [3:0] wstrb = 4'hF;
  reg remote_on_pin_n = 1, on_key_pin_n = 1, long_press_event = 0, hold_on_pin = 0;
  reg force_down_pin = 0, reset_in_pin = 0, sleep_request_pin = 1, direct_mode_pin = 1;
  reg por_ok = 1, low_supply_event = 1, high_supply_ok = 1, die_overtemp_event = 0;
  reg thermal_shutdown_event = 0, watchdog_timeout = 0, converter_shutdown_event = 0, slow = 0;
  reg [7:0] irq_events = 0;
  wire awready, wready, bvalid, arready, rvalid, seq_start, seq_done;
  wire hw_reset_pulse, swoff_reset_pulse;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] seq_sel, power_state;
  wire [7:0] res_sleep;
  integer n_errors = 0, compares = 0, i, k, n_hw = 0, n_sw = 0;
  reg [31:0] d;
  reg [1:0] r;
  // Shortened counts keep the run brief
  power_state_controller #(.REMOTE_DEB_CYC(8), .HOLD_DEB_CYC(8), .BOOT_CYC(16),
    .SWOFF_STEP_CYC(32'd20)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .remote_on_pin_n, .on_key_pin_n, .long_press_event, .hold_on_pin,
    .force_down_pin, .reset_in_pin, .sleep_request_pin, .direct_mode_pin, .por_ok,
    .low_supply_event, .high_supply_ok, .die_overtemp_event, .thermal_shutdown_event,
    .watchdog_timeout, .converter_shutdown_event, .irq_events, .seq_start, .seq_sel, .seq_done,
    .power_state, .res_sleep, .hw_reset_pulse, .swoff_reset_pulse);
  seq_model i_seq (.aclk, .aresetn, .seq_start, .slow, .seq_done);
  // Free-running clock
  always #12.5 aclk = ~aclk;
  // Reset pulses are counted for the level check at the end
  always @(posedge aclk)
  begin
    n_hw <= n_hw + (hw_reset_pulse === 1'b1);
    n_sw <= n_sw + (swoff_reset_pulse === 1'b1);
  end
  // Wide enough to keep the response code above a full data word
  task chk(input [35:0] g, input [35:0] e);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    @(posedge aclk);
    while (awready !== 1'b1) @(posedge aclk);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp; bready <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata; r = rresp; rready <= 1'b0;
  end
  endtask
  // Waits for a start, returns its distance in k; a missing start shows as a mismatch
  task wait_seq(input [2:0] sel);
  begin
    k = 0;
    do begin @(posedge aclk); k = k + 1; end while (seq_start !== 1'b1 && k < 90);
    chk({seq_start, seq_sel}, {1'b1, sel});
  end
  endtask
  task wait_state(input [2:0] st);
  begin
    for (i = 0; i < 80 && power_state !== st; i = i + 1) @(posedge aclk);
    @(posedge aclk); // Resource modes follow the state one cycle later
    chk(power_state, st);
  end
  endtask
  task no_seq(input integer n);
  begin
    k = 0;
    repeat (n) begin @(posedge aclk); if (seq_start === 1'b1) k = k + 1; end
    chk(k, 0);
  end
  endtask
  task stop_test;
  begin
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // Hang guard
  initial
  begin
    #(25 * 9000);
    n_errors = n_errors + 1;
    stop_test;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 6; k = k + 1)
    begin
      rd(k * 4);
      chk({r, d}, {`RESP_OKAY, (k == 1) ? 32'h40 : (k == 3) ? 32'hFF : 32'h0});
    end
    rd(8'h1C); chk({r, d}, {`RESP_SLVERR, 32'h0});
    wr(8'h1C, 32'h1); chk(r, `RESP_SLVERR);
    rd(`OFS_STATUS); chk(d[2:0], 3'h1);
    low_supply_event <= 1'b0; wait_state(3'h2);
    force_down_pin <= 1'b1; die_overtemp_event <= 1'b1; on_key_pin_n <= 1'b0;
    no_seq(25);
    force_down_pin <= 1'b0; die_overtemp_event <= 1'b0;
    wait_seq(3'h1); wait_state(3'h3);
    slow <= 1'b1; long_press_event <= 1'b1;
    wait_seq(3'h2); wait_state(3'h2);
    no_seq(25);
    on_key_pin_n <= 1'b1; remote_on_pin_n <= 1'b0; long_press_event <= 1'b0;
    wait_seq(3'h1); chk(k >= 10, 1);
    wait_state(3'h3); remote_on_pin_n <= 1'b1; slow <= 1'b0;
    wr(`OFS_CFG, 32'h0); wr(`OFS_SLEEP_ASG, 32'h3); wr(`OFS_EN_ASG, 32'h6);
    sleep_request_pin <= 1'b0; wait_seq(3'h3); wait_state(3'h4);
    chk(res_sleep[3:0], 4'h1);
    direct_mode_pin <= 1'b0; repeat (5) @(posedge aclk);
    chk(res_sleep[3:0], 4'h7);
    direct_mode_pin <= 1'b1; sleep_request_pin <= 1'b1;
    wait_seq(3'h4); wait_state(3'h3); chk(res_sleep[3:0], 4'h0);
    wr(`OFS_CFG, 32'h8); repeat (4) @(posedge aclk);
    chk(res_sleep[3:0], 4'h4);
    wr(`OFS_CFG, 32'h1); wr(`OFS_POLICY, 32'h00100000);
    converter_shutdown_event <= 1'b1; wait_seq(3'h2); chk(k >= 20, 1);
    converter_shutdown_event <= 1'b0; wait_seq(3'h1); wait_state(3'h3);
    watchdog_timeout <= 1'b1; no_seq(40); watchdog_timeout <= 1'b0;
    wr(`OFS_CTRL, 32'h18); wr(`OFS_CTRL, 32'h0);
    rd(`OFS_CTRL); chk(d[4:3], 2'h3);
    watchdog_timeout <= 1'b1; wait_seq(3'h2); wait_state(3'h2);
    watchdog_timeout <= 1'b0; hold_on_pin <= 1'b1; wait_seq(3'h1); wait_state(3'h3);
    hold_on_pin <= 1'b0; wait_seq(3'h2); wait_state(3'h2);
    chk(n_hw, 1); chk(n_sw, 3);
    stop_test;
  end
endmodule // test_power_state_controller
